// ===== hw/agd_top.sv
// Address generation and I/O port decode block
// Overview of operation
// - Offset is sum of base, index, displacement
// - Only index is scaled by 1,2,4,8
// - Any base register; stack pointer never indexes
// - Nine operand combinations supported
// - Offset 16 bits real, 32 bits protected
// - Real address is segment times sixteen plus offset
// - Real mode memory limited to one megabyte
// - Memory 32-bit, I/O ports 16-bit
// - I/O transfers byte, word or dword
// - No special coprocessor I/O region
// - Configuration hits produce no external cycle
// - Data port needs preceding valid index write
// - Invalid index write goes external, no change
// - Index port reads always go external
// - Enabled legacy display ports raise trap
// - Multi-byte values stored low byte first
module agd_top
(
   // Clock and reset
   input  wire logic                  CLK_I,
   input  wire logic                  RST_N_I,
   // Address request
   input  wire logic                  AGEN_REQ_I,
   input  wire agd_pkg::agd_mode_type MODE_I,
   input  wire logic [2:0]            BASE_SEL_I,
   input  wire logic [2:0]            INDEX_SEL_I,
   input  wire logic [1:0]            INDEX_SCALE_I,
   input  wire logic [31:0]           INSTR_DISPLACEMENT_I,
   input  wire logic [255:0]          GREG_FILE_I,
   input  wire logic [15:0]           SEGMENT_I,
   input  wire logic                  PROT_MODE_I,
   input  wire agd_pkg::agd_size_type MEM_SIZE_I,
   // Address answer
   output logic                       ADDR_VALID_O,
   output logic                       ADDR_FAULT_O,
   output logic [31:0]                EFFECTIVE_OFFSET_O,
   output logic [31:0]                PHYS_ADDR_O,
   output logic [3:0]                 BYTE_EN_O,
   // I/O request
   input  wire logic                  IO_REQ_I,
   input  wire logic                  IO_WRITE_I,
   input  wire logic [31:0]           IO_ADDR_I,
   input  wire agd_pkg::agd_size_type IO_SIZE_I,
   input  wire logic [31:0]           IO_WDATA_I,
   input  wire logic                  TRAP_ENABLE_B_I,
   input  wire logic                  TRAP_ENABLE_C_I,
   input  wire logic                  TRAP_ENABLE_D_I,
   // I/O answer
   output logic                       EXT_IO_O,
   output logic                       EXT_IO_WRITE_O,
   output logic [15:0]                EXT_IO_ADDR_O,
   output logic [3:0]                 EXT_IO_BE_O,
   output logic [31:0]                EXT_IO_WDATA_O,
   output logic                       CFG_WR_O,
   output logic                       CFG_RD_O,
   output logic [7:0]                 CFG_INDEX_O,
   output logic [7:0]                 CFG_WDATA_O,
   output logic                       SYSTEM_MGMT_TRAP_O
);
   import agd_pkg::*;

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   typedef struct packed
   {
      logic        addr_valid;
      logic        addr_fault;
      logic [31:0] offset;
      logic [31:0] phys;
      logic [3:0]  byte_en;
      logic        ext_io;
      logic        ext_write;
      logic [15:0] ext_addr;
      logic [3:0]  ext_be;
      logic [31:0] ext_wdata;
      logic        cfg_wr;
      logic        cfg_rd;
      logic [7:0]  cfg_index;
      logic [7:0]  cfg_wdata;
      logic        trap;
      logic        index_valid;
      logic [7:0]  held_index;
   } agd_state_type;

   agd_state_type state;
   agd_state_type next_state;

   //----------------------------------------------------------------
   // Helpers
   //----------------------------------------------------------------
   // Byte lanes for a size at a byte offset, low byte at low address
   function automatic logic [3:0] lanes(input agd_size_type sz, input logic [1:0] a);
      logic [3:0] m;
      m = 4'h1;
      unique case (sz)
         SIZE_BYTE:  m = 4'h1;
         SIZE_WORD:  m = 4'h3;
         SIZE_DWORD: m = 4'hf;
         default:    m = 4'h1;
      endcase
      lanes = 4'((m << a) & 4'hf);
   endfunction

   // Valid configuration index test
   function automatic logic idx_ok(input logic [7:0] v);
      idx_ok = ((v >= CFG_IDX_LO_MIN) && (v <= CFG_IDX_LO_MAX)) ||
               ((v >= CFG_IDX_HI_MIN) && (v <= CFG_IDX_HI_MAX));
   endfunction

   // Range test on a port address
   function automatic logic in_rng(input logic [15:0] p, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (p >= lo) && (p <= hi);
   endfunction

   //----------------------------------------------------------------
   // Operand selection
   //----------------------------------------------------------------
   logic [31:0] base_val;
   logic [31:0] index_val;
   logic [31:0] scaled;
   logic        use_base;
   logic        use_index;
   logic        use_scale;
   logic        use_disp;
   logic        bad_mode;
   logic [31:0] sum;
   logic [31:0] offset_m;
   logic [19:0] real_addr;
   logic [15:0] io_port;
   logic        is_trap;

   // Decode which parts the combination uses
   always_comb
   begin
      use_base = 1'b0;
      use_index = 1'b0;
      use_scale = 1'b0;
      use_disp = 1'b0;
      bad_mode = 1'b0;
      unique case (MODE_I)
         MODE_DISP:           use_disp = 1'b1;
         MODE_BASE:           use_base = 1'b1;
         MODE_BASE_DISP:      {use_base, use_disp} = 2'h3;
         MODE_IDX_DISP:       {use_index, use_disp} = 2'h3;
         MODE_SIDX_DISP:      {use_index, use_scale, use_disp} = 3'h7;
         MODE_BASE_IDX:       {use_base, use_index} = 2'h3;
         MODE_BASE_SIDX:      {use_base, use_index, use_scale} = 3'h7;
         MODE_BASE_IDX_DISP:  {use_base, use_index, use_disp} = 3'h7;
         MODE_BASE_SIDX_DISP: {use_base, use_index, use_scale, use_disp} = 4'hf;
         default:             bad_mode = 1'b1;
      endcase
      if (use_index && (INDEX_SEL_I == STACK_PTR_SEL))
      begin
         bad_mode = 1'b1;
      end
   end

   // Register reads and offset sum
   always_comb
   begin
      base_val = GREG_FILE_I[BASE_SEL_I * 32 +: 32];
      index_val = GREG_FILE_I[INDEX_SEL_I * 32 +: 32];
      scaled = use_scale ? 32'(index_val << INDEX_SCALE_I) : index_val;
      // sum of up to three parts
      sum = (use_base ? base_val : 32'h0) + (use_index ? scaled : 32'h0) +
            (use_disp ? INSTR_DISPLACEMENT_I : 32'h0);
      offset_m = PROT_MODE_I ? sum : {16'h0, sum[15:0]};
      real_addr = 20'({SEGMENT_I, 4'h0} + {4'h0, offset_m[15:0]});
      // ports keep low sixteen bits; no coprocessor region
      io_port = IO_ADDR_I[15:0];
      is_trap = (TRAP_ENABLE_B_I && in_rng(io_port, TRAP_B_MIN, TRAP_B_MAX)) ||
                (TRAP_ENABLE_C_I && in_rng(io_port, TRAP_C_MIN, TRAP_C_MAX)) ||
                (TRAP_ENABLE_D_I && in_rng(io_port, TRAP_D_MIN, TRAP_D_MAX));
   end

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.addr_valid = 1'b0;
      next_state.ext_io = 1'b0;
      next_state.cfg_wr = 1'b0;
      next_state.cfg_rd = 1'b0;
      next_state.trap = 1'b0;
      // Address answer
      if (AGEN_REQ_I)
      begin
         next_state.addr_valid = 1'b1;
         next_state.addr_fault = bad_mode;
         next_state.offset = offset_m;
         next_state.phys = PROT_MODE_I ? offset_m : {12'h0, real_addr & REAL_ADDR_MASK};
         next_state.byte_en = lanes(MEM_SIZE_I, next_state.phys[1:0]);
      end
      // I/O decode
      if (IO_REQ_I)
      begin
         next_state.ext_write = IO_WRITE_I;
         next_state.ext_addr = IO_ADDR_I[15:0] & IO_ADDR_MASK[15:0];
         next_state.ext_be = lanes(IO_SIZE_I, IO_ADDR_I[1:0]);
         next_state.ext_wdata = IO_WDATA_I;
         if (is_trap)
         begin
            next_state.trap = 1'b1;
         end
         else if (io_port == CFG_INDEX_PORT)
         begin
            if (!IO_WRITE_I)
            begin
               next_state.ext_io = 1'b1;
               next_state.index_valid = 1'b0;
            end
            else if (idx_ok(IO_WDATA_I[7:0]))
            begin
               // remember index for the data port
               next_state.index_valid = 1'b1;
               next_state.held_index = IO_WDATA_I[7:0];
            end
            else
            begin
               next_state.ext_io = 1'b1;
               next_state.index_valid = 1'b0;
            end
         end
         else if (io_port == CFG_DATA_PORT)
         begin
            if (state.index_valid)
            begin
               next_state.cfg_wr = IO_WRITE_I;
               next_state.cfg_rd = !IO_WRITE_I;
               next_state.cfg_index = state.held_index;
               next_state.cfg_wdata = IO_WDATA_I[7:0];
            end
            else
            begin
               next_state.ext_io = 1'b1;
            end
            next_state.index_valid = 1'b0;
         end
         else
         begin
            // any other untrapped port access breaks the pairing
            next_state.ext_io = 1'b1;
            next_state.index_valid = 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops
   assign ADDR_VALID_O = state.addr_valid;
   assign ADDR_FAULT_O = state.addr_fault;
   assign EFFECTIVE_OFFSET_O = state.offset;
   assign PHYS_ADDR_O = state.phys;
   assign BYTE_EN_O = state.byte_en;
   assign EXT_IO_O = state.ext_io;
   assign EXT_IO_WRITE_O = state.ext_write;
   assign EXT_IO_ADDR_O = state.ext_addr;
   assign EXT_IO_BE_O = state.ext_be;
   assign EXT_IO_WDATA_O = state.ext_wdata;
   assign CFG_WR_O = state.cfg_wr;
   assign CFG_RD_O = state.cfg_rd;
   assign CFG_INDEX_O = state.cfg_index;
   assign CFG_WDATA_O = state.cfg_wdata;
   assign SYSTEM_MGMT_TRAP_O = state.trap;
endmodule

// ===== hw/agd_pkg.sv
// Constants and types for the address generation and port decode block
package agd_pkg;
   // Register file size and stack pointer select
   localparam int unsigned GREG_COUNT = 8;
   localparam logic [2:0] STACK_PTR_SEL = 3'h4;
   // Operand combination codes
   typedef enum logic [3:0]
   {
      MODE_DISP = 4'h0,
      MODE_BASE = 4'h1,
      MODE_BASE_DISP = 4'h2,
      MODE_IDX_DISP = 4'h3,
      MODE_SIDX_DISP = 4'h4,
      MODE_BASE_IDX = 4'h5,
      MODE_BASE_SIDX = 4'h6,
      MODE_BASE_IDX_DISP = 4'h7,
      MODE_BASE_SIDX_DISP = 4'h8
   } agd_mode_type;
   // Transfer sizes
   typedef enum logic [1:0]
   {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_DWORD = 2'h2
   } agd_size_type;
   // Configuration ports and index ranges
   localparam logic [15:0] CFG_INDEX_PORT = 16'h0022;
   localparam logic [15:0] CFG_DATA_PORT = 16'h0023;
   localparam logic [7:0] CFG_IDX_LO_MIN = 8'hc0;
   localparam logic [7:0] CFG_IDX_LO_MAX = 8'hcf;
   localparam logic [7:0] CFG_IDX_HI_MIN = 8'hfe;
   localparam logic [7:0] CFG_IDX_HI_MAX = 8'hff;
   // Legacy display trap ranges
   localparam logic [15:0] TRAP_B_MIN = 16'h03b0;
   localparam logic [15:0] TRAP_B_MAX = 16'h03bf;
   localparam logic [15:0] TRAP_C_MIN = 16'h03c0;
   localparam logic [15:0] TRAP_C_MAX = 16'h03cf;
   localparam logic [15:0] TRAP_D_MIN = 16'h03d0;
   localparam logic [15:0] TRAP_D_MAX = 16'h03df;
   // Real mode and port address limits
   localparam logic [19:0] REAL_ADDR_MASK = 20'hfffff;
   localparam logic [31:0] IO_ADDR_MASK = 32'h0000ffff;
endpackage

// ===== verification/agd_top_assertions.sv
// Assertion checker for the address generation and port decode block
module agd_top_assertions
(
   // Clock, reset and requests
   input wire logic                  CLK_I,
   input wire logic                  RST_N_I,
   input wire logic                  AGEN_REQ_I,
   input wire agd_pkg::agd_mode_type MODE_I,
   input wire logic [2:0]            INDEX_SEL_I,
   input wire logic [15:0]           SEGMENT_I,
   input wire logic                  PROT_MODE_I,
   input wire logic                  IO_REQ_I,
   input wire logic                  IO_WRITE_I,
   input wire logic [31:0]           IO_ADDR_I,
   input wire logic [31:0]           IO_WDATA_I,
   input wire logic                  TRAP_ENABLE_B_I,
   // Answers
   input wire logic                  ADDR_VALID_O,
   input wire logic                  ADDR_FAULT_O,
   input wire logic [31:0]           EFFECTIVE_OFFSET_O,
   input wire logic [31:0]           PHYS_ADDR_O,
   input wire logic                  EXT_IO_O,
   input wire logic                  CFG_WR_O,
   input wire logic                  CFG_RD_O,
   input wire logic                  SYSTEM_MGMT_TRAP_O
);
   timeunit 1ns;
   timeprecision 1ps;
   import agd_pkg::*;
   logic p22;
   logic p23;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Requests to the two configuration ports
   assign p22 = IO_REQ_I && IO_ADDR_I[15:0] == CFG_INDEX_PORT;
   assign p23 = IO_REQ_I && IO_ADDR_I[15:0] == CFG_DATA_PORT;
   addr_answer_a: assert property (AGEN_REQ_I |=> ADDR_VALID_O)
      else $error("address request not answered");
   stack_index_a: assert property (AGEN_REQ_I && MODE_I >= MODE_IDX_DISP
      && MODE_I <= MODE_BASE_SIDX_DISP && INDEX_SEL_I == STACK_PTR_SEL |=> ADDR_FAULT_O)
      else $error("stack pointer index not refused");
   real_offset_a: assert property (AGEN_REQ_I && !PROT_MODE_I
      |=> EFFECTIVE_OFFSET_O[31:16] == 16'h0) else $error("real offset wider than 16 bits");
   real_phys_a: assert property (AGEN_REQ_I && !PROT_MODE_I |=> PHYS_ADDR_O ==
      {12'h0, {$past(SEGMENT_I), 4'h0} + EFFECTIVE_OFFSET_O[19:0]}) else $error("real address wrong");
   idx_read_a: assert property (p22 && !IO_WRITE_I |=> EXT_IO_O)
      else $error("index port read kept internal");
   bad_index_a: assert property (p22 && IO_WRITE_I && IO_WDATA_I[7:0] < CFG_IDX_LO_MIN
      |=> EXT_IO_O && !CFG_WR_O) else $error("bad index not forwarded");
   data_reuse_a: assert property (p23 ##1 p23 |=> EXT_IO_O && !CFG_WR_O && !CFG_RD_O)
      else $error("second data access reached config");
   cfg_hit_a: assert property ((p22 && IO_WRITE_I && IO_WDATA_I[7:4] == 4'hc) ##1
      (p23 && IO_WRITE_I) |=> CFG_WR_O && !EXT_IO_O) else $error("config write went outside");
   trap_b_a: assert property (IO_REQ_I && TRAP_ENABLE_B_I && IO_ADDR_I[15:4] == 12'h03b
      |=> SYSTEM_MGMT_TRAP_O && !EXT_IO_O) else $error("display port not trapped");
   read_clears_a: assert property ((p22 && !IO_WRITE_I) ##1 p23
      |=> EXT_IO_O && !CFG_WR_O && !CFG_RD_O) else $error("data access after index read kept inside");
endmodule

bind agd_top agd_top_assertions chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AGEN_REQ_I(AGEN_REQ_I),
   .MODE_I(MODE_I), .INDEX_SEL_I(INDEX_SEL_I), .SEGMENT_I(SEGMENT_I), .PROT_MODE_I(PROT_MODE_I),
   .IO_REQ_I(IO_REQ_I), .IO_WRITE_I(IO_WRITE_I), .IO_ADDR_I(IO_ADDR_I), .IO_WDATA_I(IO_WDATA_I),
   .TRAP_ENABLE_B_I(TRAP_ENABLE_B_I), .ADDR_VALID_O(ADDR_VALID_O), .ADDR_FAULT_O(ADDR_FAULT_O),
   .EFFECTIVE_OFFSET_O(EFFECTIVE_OFFSET_O), .PHYS_ADDR_O(PHYS_ADDR_O), .EXT_IO_O(EXT_IO_O),
   .CFG_WR_O(CFG_WR_O), .CFG_RD_O(CFG_RD_O), .SYSTEM_MGMT_TRAP_O(SYSTEM_MGMT_TRAP_O));

// ===== verification/agd_io_partner.sv
// External I/O bus target that counts the cycles forwarded to it
module agd_io_partner
(
   // Clock and reset
   input wire logic    clk_i,
   input wire logic    rst_n_i,
   // Forwarded cycle strobe and tally
   input wire logic    ext_io_i,
   output int unsigned ext_count_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
         ext_count_o <= 0;
      else if (ext_io_i)
         ext_count_o <= ext_count_o + 1;
   end
endmodule

// ===== verification/agd_top_tb.sv
// Self-checking testbench for the address generation and port decode block
module agd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import agd_pkg::*;
   // Design inputs
   logic         clk = 1'b0, rst_n = 1'b0, agen = 1'b0, io = 1'b0, iow = 1'b0, prot = 1'b0;
   logic         tb_b = 1'b0, tb_c = 1'b0, tb_d = 1'b0;
   agd_mode_type mode = MODE_DISP;
   agd_size_type msz = SIZE_BYTE, isz = SIZE_BYTE;
   logic [2:0]   bsel = '0, isel = '0;
   logic [1:0]   scl = '0;
   logic [15:0]  seg = '0;
   logic [31:0]  disp = '0, ioa = '0, iod = '0, seed = 32'h462b006e;
   logic [255:0] regs = '0;
   // Design outputs
   logic         av, af, ext, extw, cw, cr, trap;
   logic [3:0]   be, xbe;
   logic [7:0]   ci, cd;
   logic [15:0]  xa;
   logic [31:0]  eo, pa, xd;
   // Scoreboard state; port table entries are enables, write, port, data
   logic [75:0]  expq[$];
   logic         idx_ok = 1'b0;
   logic [7:0]   cfg_idx = '0;
   int           n_errors = 0, checks = 0, n_ext = 0;
   int unsigned  pcount;
   logic [31:0]  seq [24] = '{32'h0_1_0022_c5, 32'h0_1_0023_12, 32'h0_1_0023_34, 32'h0_1_0022_fe,
      32'h0_0_0023_00, 32'h0_1_0022_d0, 32'h0_1_0023_56, 32'h0_1_0022_cf, 32'h0_1_0080_00,
      32'h0_0_0023_00, 32'h0_0_0022_00, 32'h0_1_0022_bf, 32'h0_1_0022_c0, 32'h0_1_0022_ff,
      32'h0_0_0023_00, 32'h5_1_0022_c3, 32'h5_1_03b0_00, 32'h5_0_0023_00, 32'h5_0_03c7_00,
      32'h5_1_03df_00, 32'h5_0_03af_00, 32'h5_0_03e0_00, 32'h2_0_03c7_00, 32'h2_1_03b0_00};
   agd_top uut
   (
      .CLK_I(clk), .RST_N_I(rst_n), .AGEN_REQ_I(agen), .MODE_I(mode), .BASE_SEL_I(bsel),
      .INDEX_SEL_I(isel), .INDEX_SCALE_I(scl), .INSTR_DISPLACEMENT_I(disp), .GREG_FILE_I(regs),
      .SEGMENT_I(seg), .PROT_MODE_I(prot), .MEM_SIZE_I(msz), .ADDR_VALID_O(av),
      .ADDR_FAULT_O(af), .EFFECTIVE_OFFSET_O(eo), .PHYS_ADDR_O(pa), .BYTE_EN_O(be),
      .IO_REQ_I(io), .IO_WRITE_I(iow), .IO_ADDR_I(ioa), .IO_SIZE_I(isz), .IO_WDATA_I(iod),
      .TRAP_ENABLE_B_I(tb_b), .TRAP_ENABLE_C_I(tb_c), .TRAP_ENABLE_D_I(tb_d), .EXT_IO_O(ext),
      .EXT_IO_WRITE_O(extw), .EXT_IO_ADDR_O(xa), .EXT_IO_BE_O(xbe), .EXT_IO_WDATA_O(xd),
      .CFG_WR_O(cw), .CFG_RD_O(cr), .CFG_INDEX_O(ci), .CFG_WDATA_O(cd), .SYSTEM_MGMT_TRAP_O(trap)
   );
   agd_io_partner far_end (.clk_i(clk), .rst_n_i(rst_n), .ext_io_i(ext), .ext_count_o(pcount));
   // 20 MHz clock
   always #25 clk = ~clk;
   // Pseudo-random source
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // byte lanes from size and low address bits
   function automatic logic [3:0] lanes(input agd_size_type s, input logic [1:0] a);
      lanes = (s == SIZE_BYTE ? 4'h1 : s == SIZE_WORD ? 4'h3 : 4'hf) << a;
   endfunction
   task automatic chk(input string what, input logic [75:0] exp, input logic [75:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one address request, its result noted
   task automatic agen_req(input int m, input logic [2:0] b, input logic [2:0] x, input logic p);
      logic [31:0] off, ph;
      logic        ux;
      ux = m inside {3, 4, 5, 6, 7, 8};
      {agen, io} = 2'b10;
      mode = agd_mode_type'(4'(m));
      {bsel, isel, prot, scl, disp, seg} = {b, x, p, 2'(rnd()), rnd(), 16'(rnd())};
      msz = agd_size_type'(2'(rnd() % 3));
      off = m inside {0, 2, 3, 4, 7, 8} ? disp : 32'h0;
      if (m inside {1, 2, 5, 6, 7, 8}) off += regs[b * 32 +: 32];
      if (ux) off += regs[x * 32 +: 32] << (m inside {4, 6, 8} ? scl : 2'h0);
      if (!p) off[31:16] = 16'h0;
      ph = p ? off : {12'h0, {seg, 4'h0} + off[19:0]};
      if (m > 8) expq.push_back({8'h30, 4'h1, 64'h0});
      else expq.push_back({4'h1, lanes(msz, ph[1:0]), 3'h0, ux && x == STACK_PTR_SEL, off, ph});
      @(posedge clk);
      #2;
   endtask
   // one port access, its outcome noted
   task automatic io_req(input logic w, input logic [31:0] a, input logic [31:0] d);
      logic tr, vi;
      {agen, io, iow, ioa, iod} = {2'b01, w, a, d};
      isz = agd_size_type'(2'(rnd() % 3));
      tr = tb_b && a[15:4] == 12'h03b || tb_c && a[15:4] == 12'h03c || tb_d && a[15:4] == 12'h03d;
      vi = w && a[15:0] == CFG_INDEX_PORT && (d[7:4] == 4'hc || d[7:1] == 7'h7f);
      if (tr) expq.push_back({8'h21, 68'h0});
      else if (vi) cfg_idx = d[7:0];
      else if (a[15:0] == CFG_DATA_PORT && idx_ok)
         expq.push_back({4'h2, w ? 4'h4 : 4'h2, 52'h0, cfg_idx, w ? d[7:0] : 8'h0});
      else
      begin
         expq.push_back({8'h28, 3'h0, w, lanes(isz, a[1:0]), a[15:0], w ? d : 32'h0, 12'h0});
         n_ext++;
      end
      if (!tr) idx_ok = vi;
      @(posedge clk);
      #2;
   endtask
   // Match each answer with the oldest note
   task automatic take(input logic [75:0] g);
      logic [75:0] e;
      e = expq.size() > 0 ? expq.pop_front() : 76'h0;
      if (e[75:72] == 4'h3) g = {8'h30, 3'h0, g[64], 64'h0};
      chk("answer", e, g);
   endtask
   // Output monitor
   always @(negedge clk)
   begin
      if (av)
         take({4'h1, be, 3'h0, af, eo, pa});
      if (ext || cw || cr || trap)
         take({4'h2, ext, cw, cr, trap, ext ? {3'h0, extw, xbe, xa, extw ? xd : 32'h0, 12'h0}
            : {52'h0, (cw || cr) ? {ci, cw ? cd : 8'h0} : 16'h0}});
   end
   // Watchdog well beyond the roughly 120 cycles of tests
   initial
   begin
      #(50 * 1000);
      n_errors++;
      $display("unexpected watchdog: run did not finish");
      end_sim();
   end
   // Main sequence
   initial
   begin
      for (int i = 0; i < 8; i++)
         regs[i * 32 +: 32] = rnd();
      repeat (20) @(posedge clk);
      #2;
      rst_n = 1'b1;
      // every code in both modes, stack pointer as index for code 5
      for (int m = 0; m < 16; m++)
         for (int p = 0; p < 2; p++)
            agen_req(m, 3'(rnd()), m == 5 ? STACK_PTR_SEL : 3'(rnd()), p[0]);
      $display("test combinations done");
      repeat (40)
         agen_req(rnd() % 9, 3'(rnd()), 3'(rnd()), 1'(rnd()));
      $display("test random addresses done");
      // index then data sequences, traps and stray port accesses
      foreach (seq[i])
      begin
         {tb_b, tb_c, tb_d} = seq[i][30:28];
         io_req(seq[i][24], {16'h0, seq[i][23:8]}, {24'h0, seq[i][7:0]});
      end
      // an index port read between index and data breaks the pair
      io_req(1'b1, 32'h00000022, 32'h000000c9);
      io_req(1'b0, 32'h00000022, 32'h00000000);
      io_req(1'b1, 32'h00000023, 32'h00000077);
      $display("test port decode done");
      {tb_b, tb_c, tb_d} = 3'h0;
      // upper port bits and random sizes
      io_req(1'b1, 32'h800000f8, rnd());
      repeat (16)
         io_req(1'(rnd()), rnd(), rnd());
      $display("test random ports done");
      {agen, io} = 2'b00;
      repeat (3) @(posedge clk);
      chk("leftover notes", 76'h0, 76'(expq.size()));
      chk("external count", 76'(n_ext), 76'(pcount));
      end_sim();
   end
endmodule
